// ==== mai_pkg.sv ====
// Constants, register map and types of the motion axis I/O block
package mai_pkg;
	localparam int NAX = 8;
	localparam int CLK_HZ = 250000000;
	localparam int PWM_FREQ_HZ = 16700;
	localparam int PWM_PERIOD_DEF = CLK_HZ / PWM_FREQ_HZ;
	localparam int SAMPLE_US = 250;
	localparam int SAMPLE_DEF = SAMPLE_US * (CLK_HZ / 1000000);
	localparam int LATCH_NS = 20;
	localparam int LATCH_CYC = (LATCH_NS * (CLK_HZ / 1000000)) / 1000;
	// Axis register offsets, axis n at n * 0x40
	localparam logic [5:0] AX_CTRL = 6'h00;
	localparam logic [5:0] AX_CMD = 6'h04;
	localparam logic [5:0] AX_IDLE = 6'h08;
	localparam logic [5:0] AX_POS = 6'h0C;
	localparam logic [5:0] AX_TGT = 6'h10;
	localparam logic [5:0] AX_THR = 6'h14;
	localparam logic [5:0] AX_SLEW = 6'h18;
	localparam logic [5:0] AX_MOT = 6'h1C;
	localparam logic [5:0] AX_LATCH = 6'h20;
	localparam logic [5:0] AX_AUX = 6'h24;
	localparam logic [5:0] AX_STAT = 6'h28;
	// Global registers
	localparam logic [11:0] G_CTRL = 12'h200;
	localparam logic [11:0] G_AMPEN = 12'h204;
	localparam logic [11:0] G_OUT = 12'h208;
	localparam logic [11:0] G_OUTSET = 12'h20C;
	localparam logic [11:0] G_OUTCLR = 12'h210;
	localparam logic [11:0] G_STAT = 12'h214;
	// Axis control bits
	localparam int C_STEPPER = 0;
	localparam int C_PULSEDIR = 1;
	localparam int C_MOTOR_ON = 2;
	localparam int C_STEP_POL = 3;
	localparam int C_FWD_POL = 4;
	localparam int C_REV_POL = 5;
	localparam int C_HOME_POL = 6;
	localparam int C_DRIVE = 7;
	// Motion command bits
	localparam int M_BEGIN = 0;
	localparam int M_HOMING = 1;
	localparam int M_FIND_EDGE = 2;
	localparam int M_FIND_INDEX = 3;
	localparam int M_ARM = 4;
	localparam int M_STOP = 5;
	localparam int M_DIR = 6;
	// Status bits of an axis
	localparam int S_LIMIT_EVT = 0;
	localparam int S_LATCHED = 1;
	localparam logic [15:0] STEP_HALF_START = 16'hF000;
	localparam logic [16:0] FRAC_HALF = 17'h08000;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	typedef enum logic [4:0] {
		MS_IDLE = 5'b00001,
		MS_RUN = 5'b00010,
		MS_HOME = 5'b00100,
		MS_INDEX = 5'b01000,
		MS_DECEL = 5'b10000
	} mai_state_type;
endpackage

// ==== mai_axis_io.sv ====
// Eight-axis motion I/O: PWM/step output, encoders, limits, latch, APB
`timescale 1ns/1ns
module mai_axis_io #(
	parameter int PWM_PERIOD_CYC = mai_pkg::PWM_PERIOD_DEF,
	parameter int SAMPLE_CYC = mai_pkg::SAMPLE_DEF
)(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Encoder and switch inputs, one bit per axis
	input wire logic [7:0] quad_phase_first,
	input wire logic [7:0] quad_phase_second,
	input wire logic [7:0] enc_index,
	input wire logic [7:0] aux_phase_first,
	input wire logic [7:0] aux_phase_second,
	input wire logic [7:0] fwd_limit,
	input wire logic [7:0] rev_limit,
	input wire logic [7:0] home_switch,
	input wire logic [7:0] latch_in_n,
	// System inputs
	input wire logic abort_n,
	input wire logic reset_in_n,
	input wire logic sign_magnitude_select,
	// Motor outputs, one bit per axis
	output logic [7:0] step_pwm_o,
	output logic [7:0] step_pwm_oe,
	output logic [7:0] dir_o,
	output logic [7:0] amp_enable,
	// System outputs
	output logic error_n,
	output logic [7:0] gen_out,
	output logic program_halt,
	output logic limit_handler_routine
);
	localparam int N = mai_pkg::NAX;
	logic soft_rst;
	logic abort_act;
	logic setup_ph, wr_acc, rd_setup, glob_sel, mapped;
	logic [2:0] ax_sel;
	logic [5:0] ax_off;
	logic [31:0] rd_val;
	logic [31:0] smp_cnt_reg;
	logic smp_tick;
	logic [15:0] pwm_cnt_reg;
	logic shutdown_on_fault_reg;
	logic [7:0] ampen_reg;
	logic [7:0] out_reg;
	logic [7:0] fault_vec, limit_rise_vec;
	logic [7:0] ctrl_reg [N];
	logic [15:0] cmd_reg [N];
	logic [15:0] idle_reg [N];
	logic [15:0] eff_reg [N];
	logic [31:0] pos_reg [N];
	logic [31:0] tgt_reg [N];
	logic [31:0] thr_reg [N];
	logic [15:0] slew_reg [N];
	logic [31:0] latch_reg [N];
	logic [31:0] aux_reg [N];
	logic [1:0] stat_reg [N];
	logic armed_reg [N];
	logic dir_reg [N];
	mai_pkg::mai_state_type state_reg [N];

	// Soft reset keeps configuration, clears motion state
	// Reset pin handling
	assign soft_rst = ~reset_in_n;
	assign abort_act = ~abort_n;
	assign program_halt = abort_act;

	// APB decode; zero wait states
	assign setup_ph = psel & ~penable;
	assign wr_acc = psel & penable & pwrite & mapped;
	assign rd_setup = setup_ph & ~pwrite;
	assign glob_sel = paddr[9];
	assign ax_sel = paddr[8:6];
	assign ax_off = paddr[5:0];
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	always_comb
	begin
		mapped = 1'b0;
		if (paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0)
		begin
			if (glob_sel)
				mapped = paddr[8:0] <= mai_pkg::G_STAT[8:0];
			else
				mapped = ax_off <= mai_pkg::AX_STAT;
		end
	end

	always_comb
	begin
		rd_val = 32'h0;
		if (glob_sel)
		begin
			case (paddr)
				mai_pkg::G_CTRL: rd_val = {31'h0, shutdown_on_fault_reg};
				mai_pkg::G_AMPEN: rd_val = {24'h0, ampen_reg};
				mai_pkg::G_OUT: rd_val = {24'h0, out_reg};
				mai_pkg::G_STAT: rd_val = {22'h0, ~error_n, abort_act, fault_vec};
				default: rd_val = 32'h0;
			endcase
		end
		else
		begin
			case (ax_off)
				mai_pkg::AX_CTRL: rd_val = {24'h0, ctrl_reg[ax_sel]};
				mai_pkg::AX_CMD: rd_val = {16'h0, cmd_reg[ax_sel]};
				mai_pkg::AX_IDLE: rd_val = {16'h0, idle_reg[ax_sel]};
				mai_pkg::AX_POS: rd_val = pos_reg[ax_sel];
				mai_pkg::AX_TGT: rd_val = tgt_reg[ax_sel];
				mai_pkg::AX_THR: rd_val = thr_reg[ax_sel];
				mai_pkg::AX_SLEW: rd_val = {16'h0, slew_reg[ax_sel]};
				mai_pkg::AX_MOT: rd_val = {16'h0, eff_reg[ax_sel][15:8],
					dir_reg[ax_sel], armed_reg[ax_sel], 1'b0, state_reg[ax_sel]};
				mai_pkg::AX_LATCH: rd_val = latch_reg[ax_sel];
				mai_pkg::AX_AUX: rd_val = aux_reg[ax_sel];
				mai_pkg::AX_STAT: rd_val = {24'h0, home_switch[ax_sel],
					rev_limit[ax_sel], fwd_limit[ax_sel], fault_vec[ax_sel],
					2'h0, stat_reg[ax_sel]};
				default: rd_val = 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		// Unmapped reads give zero, not an aliased register
		else if (rd_setup)
			prdata <= mapped ? rd_val : 32'h0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			smp_cnt_reg <= 32'h0;
		else if (soft_rst || smp_cnt_reg == 32'(SAMPLE_CYC - 1))
			smp_cnt_reg <= 32'h0;
		else
			smp_cnt_reg <= smp_cnt_reg + 32'h1;
	end
	assign smp_tick = smp_cnt_reg == 32'(SAMPLE_CYC - 1);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pwm_cnt_reg <= 16'h0;
		else if (pwm_cnt_reg == 16'(PWM_PERIOD_CYC - 1))
			pwm_cnt_reg <= 16'h0;
		else
			pwm_cnt_reg <= pwm_cnt_reg + 16'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			shutdown_on_fault_reg <= 1'b0;
		else if (wr_acc && paddr == mai_pkg::G_CTRL)
			shutdown_on_fault_reg <= pwdata[0];
	end

	// Amplifier enable, dropped on abort or fault shutdown
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ampen_reg <= 8'h00;
		else if (soft_rst || abort_act)
			ampen_reg <= 8'h00;
		else if (shutdown_on_fault_reg && fault_vec != 8'h00)
			ampen_reg <= 8'h00;
		else if (wr_acc && paddr == mai_pkg::G_AMPEN)
			ampen_reg <= pwdata[7:0];
	end
	assign amp_enable = ampen_reg;

	// General outputs: set, clear or whole-port write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			out_reg <= 8'h00;
		else if (soft_rst)
			out_reg <= 8'h00;
		else if (wr_acc && paddr == mai_pkg::G_OUT)
			out_reg <= pwdata[7:0];
		else if (wr_acc && paddr == mai_pkg::G_OUTSET)
			out_reg[pwdata[2:0]] <= 1'b1;
		else if (wr_acc && paddr == mai_pkg::G_OUTCLR)
			out_reg[pwdata[2:0]] <= 1'b0;
	end
	assign gen_out = out_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			error_n <= 1'b1;
		else
			error_n <= fault_vec == 8'h00;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			limit_handler_routine <= 1'b0;
		else
			limit_handler_routine <= limit_rise_vec != 8'h00;
	end

	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_ax
			logic wsel, is_step, fwd_act, rev_act, home_act, blocked;
			logic qa_p, qb_p, xa_p, xb_p, idx_p, home_p, lat_p, lim_p;
			logic q_cnt, q_up, x_cnt, x_up, idx_rise, home_edge, lat_fall;
			logic [15:0] cmd_src, hi_cyc, half_reg, step_cnt_reg;
			logic signed [16:0] ext, frac_inv;
			logic [16:0] mag, frac_sm, frac, half_dn, half_up;
			logic [33:0] prod;
			logic [31:0] perr, perr_abs;
			logic step_lvl_reg, pwm_lvl, go_index_reg;
			assign wsel = wr_acc && !glob_sel && ax_sel == 3'(i);
			assign is_step = ctrl_reg[i][mai_pkg::C_STEPPER];
			assign fwd_act = fwd_limit[i] ^ ctrl_reg[i][mai_pkg::C_FWD_POL];
			assign rev_act = rev_limit[i] ^ ctrl_reg[i][mai_pkg::C_REV_POL];
			assign home_act = home_switch[i] ^ ctrl_reg[i][mai_pkg::C_HOME_POL];
			assign blocked = dir_reg[i] ? fwd_act : rev_act;
			assign limit_rise_vec[i] = (fwd_act | rev_act) & ~lim_p;

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					qa_p <= 1'b0;
					qb_p <= 1'b0;
					xa_p <= 1'b0;
					xb_p <= 1'b0;
					idx_p <= 1'b0;
					home_p <= 1'b0;
					lat_p <= 1'b1;
					lim_p <= 1'b0;
				end
				else
				begin
					qa_p <= quad_phase_first[i];
					qb_p <= quad_phase_second[i];
					xa_p <= aux_phase_first[i];
					xb_p <= aux_phase_second[i];
					idx_p <= enc_index[i];
					home_p <= home_act;
					lat_p <= latch_in_n[i];
					lim_p <= fwd_act | rev_act;
				end
			end

			// Four counts per quadrature cycle, one per rising pulse in pulse/direction mode; both edges changing is ignored
			always_comb
			begin
				q_up = quad_phase_first[i] ^ qb_p;
				q_cnt = (quad_phase_first[i] ^ qa_p) ^ (quad_phase_second[i] ^ qb_p);
				if (ctrl_reg[i][mai_pkg::C_PULSEDIR])
				begin
					q_cnt = quad_phase_first[i] & ~qa_p;
					q_up = quad_phase_second[i];
				end
				x_up = aux_phase_first[i] ^ xb_p;
				x_cnt = (aux_phase_first[i] ^ xa_p) ^ (aux_phase_second[i] ^ xb_p);
			end
			assign idx_rise = enc_index[i] & ~idx_p;
			assign home_edge = home_act & ~home_p;
			assign lat_fall = ~latch_in_n[i] & lat_p;

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					ctrl_reg[i] <= mai_pkg::CTRL_RESET;
					cmd_reg[i] <= 16'h0000;
					idle_reg[i] <= 16'h0000;
					tgt_reg[i] <= 32'h0;
					thr_reg[i] <= 32'hFFFFFFFF;
					slew_reg[i] <= 16'h0100;
				end
				else if (wsel)
				begin
					case (ax_off)
						mai_pkg::AX_CTRL: ctrl_reg[i] <= pwdata[7:0];
						mai_pkg::AX_CMD: cmd_reg[i] <= pwdata[15:0];
						mai_pkg::AX_IDLE: idle_reg[i] <= pwdata[15:0];
						mai_pkg::AX_TGT: tgt_reg[i] <= pwdata;
						mai_pkg::AX_THR: thr_reg[i] <= pwdata;
						mai_pkg::AX_SLEW: slew_reg[i] <= pwdata[15:0];
						default: ;
					endcase
				end
			end

			// Index zeroes position while seeking it
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					pos_reg[i] <= 32'h0;
				else if (soft_rst)
					pos_reg[i] <= 32'h0;
				else if (wsel && ax_off == mai_pkg::AX_POS)
					pos_reg[i] <= pwdata;
				else if (state_reg[i] == mai_pkg::MS_INDEX && idx_rise)
					pos_reg[i] <= 32'h0;
				else if (q_cnt)
					pos_reg[i] <= q_up ? pos_reg[i] + 32'h1 : pos_reg[i] - 32'h1;
			end

			// Auxiliary counter held at zero on stepper axes
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					aux_reg[i] <= 32'h0;
				else if (soft_rst || is_step)
					aux_reg[i] <= 32'h0;
				else if (x_cnt)
					aux_reg[i] <= x_up ? aux_reg[i] + 32'h1 : aux_reg[i] - 32'h1;
			end

			assign perr = tgt_reg[i] - pos_reg[i];
			assign perr_abs = perr[31] ? 32'h0 - perr : perr;
			assign fault_vec[i] = perr_abs > thr_reg[i];

			// Capture one cycle after the latch edge, within 20 ns
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					armed_reg[i] <= 1'b0;
					latch_reg[i] <= 32'h0;
				end
				else if (soft_rst)
					armed_reg[i] <= 1'b0;
				else if (armed_reg[i] && lat_fall)
				begin
					armed_reg[i] <= 1'b0;
					latch_reg[i] <= pos_reg[i];
				end
				else if (wsel && ax_off == mai_pkg::AX_MOT && pwdata[mai_pkg::M_ARM])
					armed_reg[i] <= 1'b1;
			end

			// Sticky status, write one to clear; a new event beats the clear
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					stat_reg[i] <= 2'h0;
				else if (soft_rst)
					stat_reg[i] <= 2'h0;
				else
				begin
					if (limit_rise_vec[i])
						stat_reg[i][mai_pkg::S_LIMIT_EVT] <= 1'b1;
					else if (wsel && ax_off == mai_pkg::AX_STAT && pwdata[0])
						stat_reg[i][mai_pkg::S_LIMIT_EVT] <= 1'b0;
					if (armed_reg[i] && lat_fall)
						stat_reg[i][mai_pkg::S_LATCHED] <= 1'b1;
					else if (wsel && ax_off == mai_pkg::AX_STAT && pwdata[1])
						stat_reg[i][mai_pkg::S_LATCHED] <= 1'b0;
				end
			end

			// Effective command: refreshed per sample, idle when off
			always_comb
			begin
				cmd_src = cmd_reg[i];
				if (!ctrl_reg[i][mai_pkg::C_MOTOR_ON])
					cmd_src = idle_reg[i];
				else if (abort_act)
					cmd_src = 16'h0000;
				// Clamp servo command toward an active limit
				else if ((!cmd_reg[i][15] && cmd_reg[i] != 16'h0 && fwd_act)
					|| (cmd_reg[i][15] && rev_act))
					cmd_src = 16'h0000;
			end
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					eff_reg[i] <= 16'h0000;
				else if (soft_rst || (abort_act && ctrl_reg[i][mai_pkg::C_MOTOR_ON]))
					eff_reg[i] <= 16'h0000;
				else if (smp_tick)
					eff_reg[i] <= cmd_src;
			end

			// Inverter duty, 32768 +/- 0.996 of command
			assign ext = {eff_reg[i][15], eff_reg[i]};
			assign frac_inv = $signed(mai_pkg::FRAC_HALF) + ext - (ext >>> 8);
			assign mag = eff_reg[i][15] ? 17'(-ext) : 17'(ext);
			assign frac_sm = (mag << 1) - ((mag << 1) >> 8);
			assign frac = sign_magnitude_select ? frac_sm : 17'(frac_inv);
			assign prod = 34'(PWM_PERIOD_CYC) * 34'(frac);
			assign hi_cyc = prod[31:16];
			assign pwm_lvl = pwm_cnt_reg < hi_cyc;

			// Motion sequencer with ramp and home stop
			assign half_dn = 17'(half_reg) - 17'((half_reg >> 3) | 16'h1);
			assign half_up = 17'(half_reg) + 17'((half_reg >> 3) | 16'h1);
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					state_reg[i] <= mai_pkg::MS_IDLE;
					half_reg <= mai_pkg::STEP_HALF_START;
					dir_reg[i] <= 1'b1;
					go_index_reg <= 1'b0;
				end
				else if (soft_rst || abort_act)
				begin
					state_reg[i] <= mai_pkg::MS_IDLE;
					half_reg <= mai_pkg::STEP_HALF_START;
				end
				else
				begin
					if (smp_tick && state_reg[i] != mai_pkg::MS_DECEL)
						half_reg <= half_dn < 17'(slew_reg[i]) ? slew_reg[i]
							: half_dn[15:0];
					else if (smp_tick)
						half_reg <= half_up[15:0];
					case (state_reg[i])
						mai_pkg::MS_IDLE:
						begin
							half_reg <= mai_pkg::STEP_HALF_START;
							if (wsel && ax_off == mai_pkg::AX_MOT
								&& pwdata[mai_pkg::M_BEGIN])
							begin
								dir_reg[i] <= pwdata[mai_pkg::M_DIR];
								go_index_reg <= pwdata[mai_pkg::M_HOMING];
								if (pwdata[mai_pkg::M_HOMING]
									|| pwdata[mai_pkg::M_FIND_EDGE])
									state_reg[i] <= mai_pkg::MS_HOME;
								else if (pwdata[mai_pkg::M_FIND_INDEX])
									state_reg[i] <= mai_pkg::MS_INDEX;
								else
									state_reg[i] <= mai_pkg::MS_RUN;
							end
						end
						mai_pkg::MS_RUN:
							if (wsel && ax_off == mai_pkg::AX_MOT
								&& pwdata[mai_pkg::M_STOP])
								state_reg[i] <= mai_pkg::MS_DECEL;
						mai_pkg::MS_HOME:
							if (home_edge)
								state_reg[i] <= go_index_reg ? mai_pkg::MS_INDEX
									: mai_pkg::MS_DECEL;
						mai_pkg::MS_INDEX:
							if (idx_rise)
								state_reg[i] <= mai_pkg::MS_DECEL;
						mai_pkg::MS_DECEL:
							if (half_up[16] || half_reg >= mai_pkg::STEP_HALF_START)
								state_reg[i] <= mai_pkg::MS_IDLE;
						default:
							state_reg[i] <= mai_pkg::MS_IDLE;
					endcase
					// Motion toward an active limit is cut off
					if (state_reg[i] != mai_pkg::MS_IDLE && blocked)
						state_reg[i] <= mai_pkg::MS_IDLE;
				end
			end

			// Equal high and low halves give 50% steps
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					step_cnt_reg <= 16'h0;
					step_lvl_reg <= 1'b0;
				end
				else if (state_reg[i] == mai_pkg::MS_IDLE || !is_step)
				begin
					step_cnt_reg <= 16'h0;
					step_lvl_reg <= 1'b0;
				end
				else if (step_cnt_reg >= half_reg)
				begin
					step_cnt_reg <= 16'h0;
					step_lvl_reg <= ~step_lvl_reg;
				end
				else
					step_cnt_reg <= step_cnt_reg + 16'h1;
			end

			// Pin low from reset; floats unless sign-magnitude or driven
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					step_pwm_o[i] <= 1'b0;
					dir_o[i] <= 1'b0;
				end
				else if (soft_rst)
				begin
					step_pwm_o[i] <= 1'b0;
					dir_o[i] <= 1'b0;
				end
				else
				begin
					step_pwm_o[i] <= is_step
						? step_lvl_reg ^ ctrl_reg[i][mai_pkg::C_STEP_POL] : pwm_lvl;
					dir_o[i] <= is_step ? dir_reg[i] : eff_reg[i][15];
				end
			end
			assign step_pwm_oe[i] = sign_magnitude_select
				| ctrl_reg[i][mai_pkg::C_DRIVE];
		end
	endgenerate
endmodule

// ==== mai_axis_io_assertions.sv ====
// Port-level checker of the motion axis I/O block, with its bind
`timescale 1ns/1ns
module mai_axis_io_assertions (
	// Clock, reset and bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// System inputs
	input wire logic abort_n,
	input wire logic reset_in_n,
	input wire logic sign_magnitude_select,
	// Watched outputs
	input wire logic [7:0] step_pwm_o,
	input wire logic [7:0] step_pwm_oe,
	input wire logic [7:0] amp_enable,
	input wire logic [7:0] gen_out,
	input wire logic program_halt
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr;
	assign wr = psel && penable && pwrite;
	chk_amp_abort: assert property (!abort_n |=> amp_enable == 8'h00)
		else $error("amp enable high after abort");
	chk_halt_level: assert property (program_halt == !abort_n)
		else $error("program halt does not follow abort");
	chk_oe_jumper: assert property
		(sign_magnitude_select |-> step_pwm_oe == 8'hFF)
		else $error("pin not driven with jumper fitted");
	chk_reset_pins: assert property ($rose(presetn) |->
		step_pwm_o == 8'h00 && step_pwm_oe == {8{sign_magnitude_select}})
		else $error("step pin state wrong after reset");
	chk_out_set: assert property (wr && paddr == mai_pkg::G_OUTSET
		|=> gen_out[$past(pwdata[2:0])] == 1'h1)
		else $error("output bit not set");
	chk_out_clear: assert property (wr && paddr == mai_pkg::G_OUTCLR
		|=> gen_out[$past(pwdata[2:0])] == 1'h0)
		else $error("output bit not cleared");
	chk_port_write: assert property (wr && paddr == mai_pkg::G_OUT
		|=> gen_out == $past(pwdata[7:0]))
		else $error("output port write lost");
	chk_soft_reset: assert property (!reset_in_n
		|=> gen_out == 8'h00 && amp_enable == 8'h00)
		else $error("soft reset left outputs set");
	cover property (wr && paddr == mai_pkg::G_OUTSET);
	cover property (!abort_n ##1 abort_n);
	cover property (!reset_in_n);
endmodule
bind mai_axis_io mai_axis_io_assertions chk (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .abort_n, .reset_in_n,
	.sign_magnitude_select, .step_pwm_o, .step_pwm_oe, .amp_enable,
	.gen_out, .program_halt);

// ==== mai_far_side.sv ====
// Encoder model of axis 0: quadrature or pulse and direction
`timescale 1ns/1ns
module mai_far_side (
	// Clock and move request
	input wire logic pclk,
	input wire logic step,
	input wire logic fwd,
	input wire logic pd_mode,
	// Encoder channels
	output logic [7:0] qa,
	output logic [7:0] qb
);
	logic [1:0] ph = 2'h0;
	logic pa = 1'h0;
	always @(posedge pclk)
		if (step && !pd_mode)
			ph <= fwd ? ph + 2'h1 : ph - 2'h1;
	always @(posedge pclk)
		if (step && pd_mode)
			pa <= !pa;
	assign qa = {7'h00, pd_mode ? pa : ph[1] ^ ph[0]};
	assign qb = {7'h00, pd_mode ? fwd : ph[1]};
endmodule

// ==== mai_axis_io_bench.sv ====
// Self-checking bench of the motion axis I/O block
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
$display("mismatch at %0t: got %0h want %0h", $time, a, e); end end
module mai_axis_io_bench;
	typedef struct {logic [7:0] c; logic s; logic [15:0] m; logic [15:0] i;
		int hi; logic d;} mai_row_type;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, q, prdata;
	logic pready, pslverr, err, error_n, halt, lhr;
	logic [7:0] qa, qb, oe, pwm, dir_o, amp, gen_out;
	logic [7:0] fwd_limit = 8'h00, latch_in_n = 8'hFF;
	logic [7:0] home = 8'h00, idx = 8'h00;
	logic abort_n = 1, reset_in_n = 1, sm = 0, step = 0, fwd = 1, pd = 0;
	int errors = 0, num_checks = 0, n;
	// Servo PWM cases: ctrl, jumper, command, idle, high cycles, sign
	mai_row_type rows [6] = '{'{8'h84, 1'h0, 16'h0000, 16'h0, 20, 1'h0},
		'{8'h84, 1'h0, 16'h7FFF, 16'h0, 39, 1'h0},
		'{8'h84, 1'h0, 16'h8000, 16'h0, 0, 1'h1},
		'{8'h80, 1'h0, 16'h0000, 16'h7FFF, 39, 1'h0},
		'{8'h84, 1'h1, 16'h0000, 16'h0, 0, 1'h0},
		'{8'h84, 1'h1, 16'hC000, 16'h0, 19, 1'h1}};
	mai_axis_io #(.PWM_PERIOD_CYC(40), .SAMPLE_CYC(20)) dut (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.quad_phase_first(qa), .quad_phase_second(qb), .enc_index(idx),
		.aux_phase_first(8'h00), .aux_phase_second(8'h00), .fwd_limit,
		.rev_limit(8'h00), .home_switch(home), .latch_in_n, .abort_n,
		.reset_in_n, .sign_magnitude_select(sm), .step_pwm_o(pwm),
		.step_pwm_oe(oe), .dir_o, .amp_enable(amp), .error_n,
		.gen_out, .program_halt(halt), .limit_handler_routine(lhr));
	mai_far_side far (.pclk, .step, .fwd, .pd_mode(pd), .qa, .qb);
	always #2 pclk = ~pclk;
	task results;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		q = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rc(input logic [11:0] a, input logic [31:0] e);
		xf(1'h0, a, 32'h0);
		`CHK(q, e)
	endtask
	task wo(input logic [11:0] a, input logic [31:0] d, input logic [7:0] e);
		xf(1'h1, a, d);
		@(posedge pclk);
		`CHK(gen_out, e)
	endtask
	// One model step every 22 clock cycles
	task mv(input int k, input logic f);
		fwd <= f;
		repeat (k)
		begin
			@(posedge pclk) step <= 1;
			@(posedge pclk) step <= 0;
			repeat (20) @(posedge pclk);
		end
	endtask
	task lt;
		@(posedge pclk) latch_in_n <= 8'hFE;
		@(posedge pclk) latch_in_n <= 8'hFF;
		repeat (3) @(posedge pclk);
	endtask
	initial
	begin
		repeat (10000) @(posedge pclk);
		errors++;
		results();
	end
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(negedge pclk);
		`CHK({oe, pwm}, 16'h0000)
		`CHK(error_n, 1'h1)
		rc(12'h014, 32'hFFFFFFFF);
		rc(12'h018, 32'h00000100);
		rc(12'h414, 32'h0);
		`CHK(err, 1'h1)
		$display("reset test done");
		foreach (rows[i])
		begin
			sm <= rows[i].s;
			xf(1'h1, 12'h000, {24'h0, rows[i].c});
			xf(1'h1, 12'h004, {16'h0, rows[i].m});
			xf(1'h1, 12'h008, {16'h0, rows[i].i});
			repeat (80) @(posedge pclk);
			n = 0;
			repeat (40) @(negedge pclk) n += pwm[0];
			`CHK(n, rows[i].hi)
			`CHK(dir_o[0], rows[i].d)
			$display("pwm row %0d done", i);
		end
		wo(12'h208, 32'hA5, 8'hA5);
		wo(12'h20C, 32'h1, 8'hA7);
		wo(12'h210, 32'h0, 8'hA6);
		wo(12'h210, 32'h7, 8'h26);
		wo(12'h20C, 32'h6, 8'h66);
		$display("output test done");
		sm <= 0;
		xf(1'h1, 12'h000, 32'h0);
		xf(1'h1, 12'h00C, 32'h0);
		mv(8, 1'h1);
		mv(4, 1'h0);
		rc(12'h00C, 32'h4);
		xf(1'h1, 12'h000, 32'h2);
		pd <= 1;
		mv(8, 1'h1);
		pd <= 0;
		rc(12'h00C, 32'h8);
		xf(1'h1, 12'h000, 32'h0);
		$display("encoder test done");
		xf(1'h1, 12'h01C, 32'h10);
		lt();
		rc(12'h020, 32'h8);
		mv(2, 1'h1);
		lt();
		rc(12'h020, 32'h8);
		rc(12'h028, 32'h2);
		$display("latch test done");
		xf(1'h1, 12'h010, 32'd100);
		xf(1'h1, 12'h014, 32'd10);
		repeat (3) @(negedge pclk);
		`CHK(error_n, 1'h0)
		xf(1'h1, 12'h200, 32'h1);
		xf(1'h1, 12'h204, 32'hFF);
		repeat (2) @(negedge pclk);
		`CHK(amp, 8'h00)
		xf(1'h1, 12'h014, 32'hFFFFFFFF);
		xf(1'h1, 12'h204, 32'hFF);
		repeat (2) @(negedge pclk);
		`CHK(amp, 8'hFF)
		abort_n <= 0;
		repeat (2) @(negedge pclk);
		`CHK({amp, halt}, 9'h001)
		@(posedge pclk) abort_n <= 1;
		$display("fault test done");
		xf(1'h1, 12'h018, 32'h80);
		@(posedge pclk) reset_in_n <= 0;
		@(posedge pclk) reset_in_n <= 1;
		repeat (2) @(negedge pclk);
		`CHK(gen_out, 8'h00)
		rc(12'h00C, 32'h0);
		rc(12'h018, 32'h80);
		@(posedge pclk) fwd_limit <= 8'h01;
		n = 0;
		repeat (10) @(negedge pclk) n += lhr;
		`CHK(n, 1)
		rc(12'h028, 32'h21);
		sm <= 1;
		@(negedge pclk);
		`CHK(oe, 8'hFF)
		xf(1'h1, 12'h01C, 32'h41);
		rc(12'h01C, 32'h81);
		$display("reset and limit test done");
		@(posedge pclk) fwd_limit <= 8'h00;
		xf(1'h1, 12'h00C, 32'h55);
		xf(1'h1, 12'h01C, 32'h43);
		rc(12'h01C, 32'h84);
		@(posedge pclk) home <= 8'h01;
		rc(12'h01C, 32'h88);
		@(posedge pclk) idx <= 8'h01;
		rc(12'h00C, 32'h0);
		repeat (1100) @(posedge pclk);
		rc(12'h01C, 32'h81);
		$display("homing test done");
		xf(1'h1, 12'h000, 32'h89);
		xf(1'h1, 12'h01C, 32'h41);
		repeat (1500) @(posedge pclk);
		n = 0;
		repeat (258) @(negedge pclk) n += pwm[0];
		`CHK(n, 129)
		`CHK(dir_o[0], 1'h1)
		$display("stepper test done");
		results();
	end
endmodule
